// [include/dfpl_pkg.sv]
package dfpl_pkg;

  // --------------------------------------------------------------
  // clock
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;

  // --------------------------------------------------------------
  // protection times, in their own units
  // --------------------------------------------------------------
  localparam int SHORT_FILTER_NS = 10000;
  localparam int INRUSH_BLANK_TIME_NS = 200000;
  localparam int LAMP_RETRY_US = 10000;

  // --------------------------------------------------------------
  // derived cycle counts (least times round up)
  // --------------------------------------------------------------
  localparam int SHORT_FILTER_CYC = (SHORT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INRUSH_BLANK_CYC =
    (INRUSH_BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LAMP_RETRY_CYC = (LAMP_RETRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // --------------------------------------------------------------
  // timer width and reset values
  // --------------------------------------------------------------
  localparam int TIMER_CNT_W = 20;
  localparam logic RST_DRIVE = 1'h0;
  localparam logic RST_FLAG = 1'h0;
  localparam logic [2:0] RST_CMD = 3'h0;

  // --------------------------------------------------------------
  // command vector positions
  // --------------------------------------------------------------
  localparam int CMD_SPARK = 0;
  localparam int CMD_RELAY = 1;
  localparam int CMD_LAMP = 2;

endpackage

// [include/dfpl_tmr_if.sv]
`timescale 1ns/10ps

// run request and elapsed level between a channel and its timer
interface dfpl_tmr_if;
  logic run;
  logic expired;

  modport owner
  (
    output run,
    input expired
  );

  modport timer
  (
    input run,
    output expired
  );
endinterface

// [hdl/dfpl_timer.sv]
`timescale 1ns/10ps

// counts clock cycles while run is high; expired rises after LIMIT
// cycles of continuous run and holds until run drops
module dfpl_timer
#(
  parameter int CNT_W = dfpl_pkg::TIMER_CNT_W,
  parameter int LIMIT = dfpl_pkg::SHORT_FILTER_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // run request and elapsed level
  dfpl_tmr_if.timer tmr
);

  // --------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------
  if (LIMIT < 1 || LIMIT >= (2 ** CNT_W))
  begin : g_bad_limit
    $error("timer limit does not fit the counter");
  end

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic expired_r;
  logic expired_nxt;
  wire at_last = (cnt_r == LAST);

  assign cnt_nxt = (!tmr.run || expired_r) ? '0 : cnt_r + CNT_W'(1);
  assign expired_nxt = tmr.run && (expired_r || at_last);
  assign tmr.expired = expired_r;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      expired_r <= 1'h0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      expired_r <= expired_nxt;
    end
  end

endmodule

// [hdl/dfpl_fault_logic.sv]
// What this block does
// - spark command high drives source output; low drives sink to switch off.
// - overcurrent or short on the external spark transistor raises the spark flag.
// - open coil sensed while spark channel is off raises the spark flag.
// - supply overvoltage turns both spark drives off; source stays off until cleared and command rises.
// - spark flag stays high until the command goes low then high.
// - relay command high turns the relay sink on; low turns it off.
// - relay hard short turns output off after filter; needs command low-high.
// - relay short or overtemperature raises the relay flag.
// - relay overtemperature forces output off until cooled below hysteresis.
// - relay open load while off raises the relay flag.
// - relay drain above short threshold while on raises the relay flag.
// - relay flag stays high until the command goes low then rises.
// - lamp command high turns the lamp sink on; low turns it off.
// - lamp short off is retried by an internal timer without command toggle.
// - the lamp channel has no fault flag output.
// - lamp overtemperature forces output off until cooled below hysteresis.
// - the lamp channel does no open load detection.
// - lamp overcurrent is ignored during an inrush blanking time after switch-on.
// - after overvoltage or undervoltage the spark source comes back off; the sink follows the command.
// - relay and lamp resume after overvoltage; after undervoltage they stay off until their command rises.
`timescale 1ns/10ps

module dfpl_fault_logic
#(
  parameter int INRUSH_BLANK_CYC = dfpl_pkg::INRUSH_BLANK_CYC,
  parameter int LAMP_RETRY_CYC = dfpl_pkg::LAMP_RETRY_CYC,
  parameter int TIMER_CNT_W = dfpl_pkg::TIMER_CNT_W
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // controller commands
  input wire logic spark_command,
  input wire logic relay_command,
  input wire logic lamp_command,
  // supply monitors
  input wire logic supply_overvoltage,
  input wire logic supply_undervoltage,
  // spark sense comparators
  input wire logic spark_overcurrent,
  input wire logic spark_open_load,
  input wire logic spark_overtemp,
  // relay sense comparators
  input wire logic relay_short_sense,
  input wire logic relay_drain_high,
  input wire logic relay_open_load,
  input wire logic relay_temp_over,
  input wire logic relay_temp_cool,
  // lamp sense comparators
  input wire logic lamp_short_sense,
  input wire logic lamp_temp_over,
  input wire logic lamp_temp_cool,
  // spark drives and flag
  output logic spark_source_drive,
  output logic spark_sink_drive,
  output logic spark_fault_flag,
  // relay drive and flag
  output logic relay_output,
  output logic relay_fault_flag,
  // lamp drive
  output logic lamp_output
);

  // --------------------------------------------------------------
  // parameter check
  // --------------------------------------------------------------
  if (INRUSH_BLANK_CYC < 1 || INRUSH_BLANK_CYC >= (2 ** TIMER_CNT_W))
  begin : g_bad_blank
    $error("blanking count does not fit the timers");
  end

  if (LAMP_RETRY_CYC < 1 || LAMP_RETRY_CYC >= (2 ** TIMER_CNT_W))
  begin : g_bad_retry
    $error("retry count does not fit the timers");
  end

  if (TIMER_CNT_W < 1 || TIMER_CNT_W > 30 ||
      dfpl_pkg::SHORT_FILTER_CYC >= (2 ** TIMER_CNT_W))
  begin : g_bad_width
    $error("timer width cannot hold the short filter count");
  end

  // --------------------------------------------------------------
  // latch helpers
  // --------------------------------------------------------------
  // a raise in the clearing cycle wins
  function automatic logic latch_next
  (
    input logic raise,
    input logic held,
    input logic clear
  );
    return raise | (held & ~clear);
  endfunction

  // a low-side switch may close only with no latch and no supply event
  function automatic logic lowside_on
  (
    input logic command,
    input logic therm,
    input logic uv_lock,
    input logic shorted,
    input logic supply_event
  );
    return command & ~therm & ~uv_lock & ~shorted & ~supply_event;
  endfunction

  // --------------------------------------------------------------
  // command edges and supply events
  // --------------------------------------------------------------
  // edge register resets low: a command already high at release is an edge
  logic [2:0] cmd_d_r;
  wire [2:0] cmd = {lamp_command, relay_command, spark_command};
  wire [2:0] cmd_rise = cmd & ~cmd_d_r;
  wire supply_bad = supply_overvoltage | supply_undervoltage;

  // one sample register per command pin
  for (genvar ch = 0; ch < 3; ch++)
  begin : g_cmd_edge
    always_ff @(posedge mclk or negedge rstn)
    begin
      if (!rstn)
      begin
        cmd_d_r[ch] <= dfpl_pkg::RST_CMD[ch];
      end
      else
      begin
        cmd_d_r[ch] <= cmd[ch];
      end
    end
  end

  // --------------------------------------------------------------
  // spark channel
  // --------------------------------------------------------------
  logic spark_lock_r;
  logic spark_lock_nxt;
  logic spark_source_r;
  logic spark_sink_r;
  logic spark_flag_r;
  logic spark_flag_nxt;
  wire spark_rise = cmd_rise[dfpl_pkg::CMD_SPARK];

  // lock is entered on any supply event and left only on a fresh rising edge
  assign spark_lock_nxt = latch_next(supply_bad, spark_lock_r, spark_rise);

  wire spark_block = spark_lock_nxt;
  wire spark_on_nxt = spark_command & ~spark_block;
  // sink follows the command and the supply: locked with the command high, both stay off
  wire spark_sink_nxt = ~spark_command & ~supply_bad;

  // open coil counts only while off; overtemperature counts always
  wire spark_fault_ev =
    (spark_overcurrent & spark_source_r) |
    (spark_open_load & ~spark_command) |
    (supply_overvoltage & spark_command) |
    spark_overtemp;

  // an event in the clearing cycle keeps the flag set
  assign spark_flag_nxt = latch_next(spark_fault_ev, spark_flag_r, spark_rise);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      spark_lock_r <= 1'h0;
      spark_source_r <= dfpl_pkg::RST_DRIVE;
      spark_sink_r <= dfpl_pkg::RST_DRIVE;
      spark_flag_r <= dfpl_pkg::RST_FLAG;
    end
    else
    begin
      spark_lock_r <= spark_lock_nxt;
      spark_source_r <= spark_on_nxt;
      spark_sink_r <= spark_sink_nxt;
      spark_flag_r <= spark_flag_nxt;
    end
  end

  assign spark_source_drive = spark_source_r;
  assign spark_sink_drive = spark_sink_r;
  assign spark_fault_flag = spark_flag_r;

  // --------------------------------------------------------------
  // relay channel
  // --------------------------------------------------------------
  dfpl_tmr_if relay_filt_if ();

  logic relay_therm_r;
  logic relay_uv_lock_r;
  logic relay_short_r;
  logic relay_out_r;
  logic relay_flag_r;
  wire relay_rise = cmd_rise[dfpl_pkg::CMD_RELAY];

  // short filter runs only while the sink is on and the short is sensed
  assign relay_filt_if.run = relay_out_r & relay_short_sense;

  wire relay_therm_nxt = latch_next(relay_temp_over, relay_therm_r, relay_temp_cool);
  wire relay_uv_lock_nxt = latch_next(supply_undervoltage, relay_uv_lock_r, relay_rise);
  wire relay_short_nxt = latch_next(relay_filt_if.expired, relay_short_r, relay_rise);

  // overvoltage only blanks the output; it follows the command again on exit
  wire relay_on_nxt = lowside_on(relay_command, relay_therm_nxt, relay_uv_lock_nxt,
    relay_short_nxt, supply_bad);

  // overvoltage while commanded on is reported, as on the spark channel
  wire relay_fault_ev =
    relay_filt_if.expired | relay_temp_over |
    (relay_open_load & ~relay_command) |
    (relay_drain_high & relay_out_r) |
    (supply_overvoltage & relay_command);

  wire relay_flag_nxt = latch_next(relay_fault_ev, relay_flag_r, relay_rise);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      relay_therm_r <= 1'h0;
      relay_uv_lock_r <= 1'h0;
      relay_short_r <= 1'h0;
      relay_out_r <= dfpl_pkg::RST_DRIVE;
      relay_flag_r <= dfpl_pkg::RST_FLAG;
    end
    else
    begin
      relay_therm_r <= relay_therm_nxt;
      relay_uv_lock_r <= relay_uv_lock_nxt;
      relay_short_r <= relay_short_nxt;
      relay_out_r <= relay_on_nxt;
      relay_flag_r <= relay_flag_nxt;
    end
  end

  // the filter restarts whenever the short sense drops before it elapses
  dfpl_timer
  #(
    .CNT_W(TIMER_CNT_W),
    .LIMIT(dfpl_pkg::SHORT_FILTER_CYC)
  )
  u_relay_filt
  (
    .mclk(mclk),
    .rstn(rstn),
    .tmr(relay_filt_if.timer)
  );

  assign relay_output = relay_out_r;
  assign relay_fault_flag = relay_flag_r;

  // --------------------------------------------------------------
  // lamp channel
  // --------------------------------------------------------------
  // faults here only protect the switch: no flag leaves the block
  // and no open load sense exists for this channel
  dfpl_tmr_if lamp_blank_if ();
  dfpl_tmr_if lamp_filt_if ();
  dfpl_tmr_if lamp_retry_if ();

  logic lamp_therm_r;
  logic lamp_uv_lock_r;
  logic lamp_short_r;
  logic lamp_out_r;
  wire lamp_rise = cmd_rise[dfpl_pkg::CMD_LAMP];

  // blanking starts at switch-on; overcurrent counts only once it has elapsed
  assign lamp_blank_if.run = lamp_out_r;
  assign lamp_filt_if.run = lamp_out_r & lamp_blank_if.expired & lamp_short_sense;
  // retry period runs while the short shutdown stands
  assign lamp_retry_if.run = lamp_short_r;

  wire lamp_therm_nxt = latch_next(lamp_temp_over, lamp_therm_r, lamp_temp_cool);
  wire lamp_uv_lock_nxt = latch_next(supply_undervoltage, lamp_uv_lock_r, lamp_rise);
  // shutdown is left when the retry period ends, with no command toggle
  wire lamp_short_nxt =
    latch_next(lamp_filt_if.expired, lamp_short_r, lamp_retry_if.expired);

  wire lamp_on_nxt = lowside_on(lamp_command, lamp_therm_nxt, lamp_uv_lock_nxt,
    lamp_short_nxt, supply_bad);

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lamp_therm_r <= 1'h0;
      lamp_uv_lock_r <= 1'h0;
      lamp_short_r <= 1'h0;
      lamp_out_r <= dfpl_pkg::RST_DRIVE;
    end
    else
    begin
      lamp_therm_r <= lamp_therm_nxt;
      lamp_uv_lock_r <= lamp_uv_lock_nxt;
      lamp_short_r <= lamp_short_nxt;
      lamp_out_r <= lamp_on_nxt;
    end
  end

  // blanking restarts at every switch-on, a retry included
  dfpl_timer
  #(
    .CNT_W(TIMER_CNT_W),
    .LIMIT(INRUSH_BLANK_CYC)
  )
  u_lamp_blank
  (
    .mclk(mclk),
    .rstn(rstn),
    .tmr(lamp_blank_if.timer)
  );

  dfpl_timer
  #(
    .CNT_W(TIMER_CNT_W),
    .LIMIT(dfpl_pkg::SHORT_FILTER_CYC)
  )
  u_lamp_filt
  (
    .mclk(mclk),
    .rstn(rstn),
    .tmr(lamp_filt_if.timer)
  );

  dfpl_timer
  #(
    .CNT_W(TIMER_CNT_W),
    .LIMIT(LAMP_RETRY_CYC)
  )
  u_lamp_retry
  (
    .mclk(mclk),
    .rstn(rstn),
    .tmr(lamp_retry_if.timer)
  );

  assign lamp_output = lamp_out_r;

endmodule

// [tb/dfpl_fault_logic_asserts.sv]
`timescale 1ns/10ps

module dfpl_fault_logic_asserts
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // commands and sense
  input wire logic spark_command,
  input wire logic relay_command,
  input wire logic lamp_command,
  input wire logic supply_overvoltage,
  input wire logic supply_undervoltage,
  input wire logic relay_short_sense,
  input wire logic relay_temp_over,
  input wire logic lamp_temp_over,
  // drives and flags
  input wire logic spark_source_drive,
  input wire logic spark_sink_drive,
  input wire logic spark_fault_flag,
  input wire logic relay_output,
  input wire logic relay_fault_flag,
  input wire logic lamp_output
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence spark_held;
    spark_fault_flag && spark_command ##1 spark_fault_flag && spark_command;
  endsequence
  sequence relay_held;
    relay_fault_flag && relay_command ##1 relay_fault_flag && relay_command;
  endsequence
  sequence relay_shorted;
    relay_output && $rose(relay_short_sense) ##1 (relay_short_sense && relay_command) [*8];
  endsequence

  AST_SPARK_OFF: assert property (!spark_command |=> !spark_source_drive)
    else $error("spark source on without command");
  AST_SPARK_OV: assert property (supply_overvoltage |=> !spark_source_drive && !spark_sink_drive)
    else $error("spark drive on in overvoltage");
  AST_SPARK_SINK: assert property (spark_command |=> !spark_sink_drive)
    else $error("spark sink on while commanded");
  AST_SPARK_HOLD: assert property (spark_held |=> spark_fault_flag)
    else $error("spark flag cleared without rising command");
  AST_RELAY_OFF: assert property (!relay_command |=> !relay_output)
    else $error("relay on without command");
  AST_RELAY_SHORT: assert property (relay_shorted |-> ##[1:600] (!relay_output || !relay_short_sense))
    else $error("relay not cut off by short");
  AST_RELAY_HOT: assert property (relay_temp_over |=> !relay_output && relay_fault_flag)
    else $error("relay hot but on or unflagged");
  AST_RELAY_HOLD: assert property (relay_held |=> relay_fault_flag)
    else $error("relay flag cleared without rising command");
  AST_LAMP_OFF: assert property (!lamp_command |=> !lamp_output)
    else $error("lamp on without command");
  AST_LAMP_HOT: assert property (lamp_temp_over |=> !lamp_output)
    else $error("lamp on while hot");
  AST_SUPPLY: assert property ((supply_overvoltage || supply_undervoltage) |=>
    !relay_output && !lamp_output && !spark_source_drive)
    else $error("output on during supply event");
endmodule

bind dfpl_fault_logic dfpl_fault_logic_asserts dfpl_fault_logic_asserts_i
(
  .mclk(mclk), .rstn(rstn), .spark_command(spark_command), .relay_command(relay_command),
  .lamp_command(lamp_command), .supply_overvoltage(supply_overvoltage),
  .supply_undervoltage(supply_undervoltage), .relay_short_sense(relay_short_sense),
  .relay_temp_over(relay_temp_over), .lamp_temp_over(lamp_temp_over),
  .spark_source_drive(spark_source_drive), .spark_sink_drive(spark_sink_drive),
  .spark_fault_flag(spark_fault_flag), .relay_output(relay_output),
  .relay_fault_flag(relay_fault_flag), .lamp_output(lamp_output)
);

// [tb/dfpl_mcu_model.sv]
`timescale 1ns/10ps

// controller side: command pins change only just after a clock edge
module dfpl_mcu_model
(
  // clock
  input wire logic mclk,
  // command pins
  output logic spark_command,
  output logic relay_command,
  output logic lamp_command
);
  initial {lamp_command, relay_command, spark_command} = 3'h0;

  task automatic drive(input logic [2:0] cmd);
    @(posedge mclk);
    spark_command <= cmd[dfpl_pkg::CMD_SPARK];
    relay_command <= cmd[dfpl_pkg::CMD_RELAY];
    lamp_command <= cmd[dfpl_pkg::CMD_LAMP];
  endtask
endmodule

// [tb/dfpl_fault_logic_tb.sv]
`timescale 1ns/10ps

module dfpl_fault_logic_tb;
  logic mclk;
  logic rstn;
  // ov uv spk_oc spk_open spk_hot rly_short rly_drain rly_open rly_hot rly_cool lmp_short..cool
  logic [12:0] sense;
  wire [2:0] cmd;
  // spark src, sink, flag, relay out, flag, lamp out
  wire [5:0] outs;
  int mismatches;
  int samples_checked;

  dfpl_mcu_model dfpl_mcu_model_i (.mclk(mclk), .spark_command(cmd[0]),
    .relay_command(cmd[1]), .lamp_command(cmd[2]));

  dfpl_fault_logic #(.INRUSH_BLANK_CYC(20), .LAMP_RETRY_CYC(50),
    .TIMER_CNT_W(dfpl_pkg::TIMER_CNT_W)) dfpl_fault_logic_i
  (
    .mclk(mclk), .rstn(rstn), .spark_command(cmd[0]), .relay_command(cmd[1]),
    .lamp_command(cmd[2]), .supply_overvoltage(sense[0]), .supply_undervoltage(sense[1]),
    .spark_overcurrent(sense[2]), .spark_open_load(sense[3]), .spark_overtemp(sense[4]),
    .relay_short_sense(sense[5]), .relay_drain_high(sense[6]), .relay_open_load(sense[7]),
    .relay_temp_over(sense[8]), .relay_temp_cool(sense[9]), .lamp_short_sense(sense[10]),
    .lamp_temp_over(sense[11]), .lamp_temp_cool(sense[12]),
    .spark_source_drive(outs[5]), .spark_sink_drive(outs[4]), .spark_fault_flag(outs[3]),
    .relay_output(outs[2]), .relay_fault_flag(outs[1]), .lamp_output(outs[0])
  );

  initial
  begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // drive commands and sense at one edge, wait n edges, compare outputs
  task automatic go(input logic [2:0] c, input logic [12:0] s, input int n,
    input logic [5:0] exp);
    dfpl_mcu_model_i.drive(c);
    sense <= s;
    repeat (n) @(posedge mclk);
    #1;
    check(outs, exp);
  endtask

  task automatic spark_case;
    go(3'h0, 13'h1200, 2, 6'h10);
    go(3'h1, 13'h1200, 2, 6'h20);
    go(3'h1, 13'h1201, 2, 6'h08);
    go(3'h1, 13'h1200, 3, 6'h08);
    go(3'h0, 13'h1200, 2, 6'h18);
    go(3'h1, 13'h1200, 2, 6'h20);
    go(3'h0, 13'h1208, 2, 6'h18);
    go(3'h1, 13'h1200, 2, 6'h20);
    go(3'h1, 13'h1204, 2, 6'h28);
    go(3'h0, 13'h1200, 2, 6'h18);
    go(3'h1, 13'h1200, 2, 6'h20);
    go(3'h0, 13'h1200, 2, 6'h10);
    go(3'h1, 13'h1210, 2, 6'h28);
    go(3'h0, 13'h1200, 2, 6'h18);
    go(3'h1, 13'h1200, 2, 6'h20);
    go(3'h0, 13'h1200, 2, 6'h10);
  endtask

  task automatic relay_case;
    go(3'h2, 13'h1200, 2, 6'h14);
    go(3'h2, 13'h1100, 2, 6'h12);
    go(3'h2, 13'h1200, 2, 6'h16);
    go(3'h0, 13'h1200, 2, 6'h12);
    go(3'h2, 13'h1200, 2, 6'h14);
    go(3'h2, 13'h1240, 2, 6'h16);
    go(3'h0, 13'h1280, 2, 6'h12);
    go(3'h2, 13'h1200, 2, 6'h14);
    go(3'h2, 13'h1220, 400, 6'h14);
    go(3'h2, 13'h1220, 150, 6'h12);
    go(3'h2, 13'h1200, 2, 6'h12);
    go(3'h0, 13'h1200, 2, 6'h12);
    go(3'h2, 13'h1200, 2, 6'h14);
    go(3'h0, 13'h1200, 2, 6'h10);
  endtask

  task automatic lamp_case;
    go(3'h4, 13'h1200, 2, 6'h11);
    go(3'h4, 13'h0a00, 2, 6'h10);
    go(3'h4, 13'h1200, 2, 6'h11);
    go(3'h0, 13'h1200, 2, 6'h10);
    go(3'h4, 13'h1600, 505, 6'h11);
    go(3'h4, 13'h1600, 30, 6'h10);
    go(3'h4, 13'h1200, 70, 6'h11);
    go(3'h0, 13'h1200, 2, 6'h10);
  endtask

  task automatic supply_case;
    go(3'h7, 13'h1200, 2, 6'h25);
    go(3'h7, 13'h1201, 2, 6'h0a);
    go(3'h7, 13'h1200, 3, 6'h0f);
    go(3'h7, 13'h1202, 2, 6'h0a);
    go(3'h7, 13'h1200, 3, 6'h0a);
    go(3'h1, 13'h1200, 2, 6'h0a);
    go(3'h7, 13'h1200, 3, 6'h0d);
    go(3'h0, 13'h1200, 2, 6'h18);
    go(3'h7, 13'h1200, 2, 6'h25);
    go(3'h0, 13'h1200, 2, 6'h10);
  endtask

  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    rstn = 1'h0;
    sense = 13'h1200;
    repeat (5) @(posedge mclk);
    rstn <= 1'h1;
    repeat (2) @(posedge mclk);
    #1;
    spark_case();
    relay_case();
    lamp_case();
    supply_case();
    conclude();
  end

  initial
  begin
    #1000000;
    mismatches++;
    conclude();
  end
endmodule
